// ### common/acd_pkg.sv
package acd_pkg;
  localparam int ADDR_W = 14;
  localparam int DATA_W = 32;
  localparam int REG_W  = 8;
  localparam int RES_W  = 10;
  localparam int CHAN_W = 4;
  localparam int CNT_W  = 13;
  localparam int IRQ_W  = 2;

  // Register indices; byte address is four times the index
  localparam logic [11:0] IDX_CONV_CTL = 12'hf70;
  localparam logic [11:0] IDX_RES_HI   = 12'hf72;
  localparam logic [11:0] IDX_RES_LO   = 12'hf73;
  localparam logic [11:0] IDX_IRQ_STAT = 12'hf74;
  localparam logic [11:0] IDX_IRQ_MASK = 12'hf75;
  localparam logic [11:0] IDX_DMA_CTL  = 12'hfbe;
  localparam logic [1:0]  BYTE_OFS     = 2'h0;

  // Conversion times in system clock cycles
  localparam logic [CNT_W-1:0] SINGLE_CYCLES_DFLT = 13'h1409;
  localparam logic [CNT_W-1:0] CONTINUOUS_SELECT_CYCLES        = 13'h0100;
  localparam logic [CNT_W-1:0] CNT_ONE            = 13'h0001;

  localparam logic [CHAN_W-1:0] LAST_MAX = 4'hb;
  localparam logic [CHAN_W-1:0] CHAN_ONE = 4'h1;

  localparam int IRQ_CONV = 0;
  localparam int IRQ_SCAN = 1;

  typedef struct packed {
    logic              en;
    logic              irq_en;
    logic [1:0]        rsv;
    logic [CHAN_W-1:0] last;
  } acd_dma_ctl_t;

  typedef struct packed {
    logic              start;
    logic              rsv;
    logic              vref_ext;
    logic              continuous_select;
    logic [CHAN_W-1:0] chan;
  } acd_conv_ctl_t;

  localparam acd_dma_ctl_t  DMA_CTL_RST  = 8'h00;
  localparam acd_conv_ctl_t CONV_CTL_RST = 8'h00;

  typedef enum logic [1:0] {
    ACD_IDLE = 2'h0,
    ACD_CONV = 2'h1,
    ACD_XFER = 2'h3
  } acd_fsm_t;

  typedef struct packed {
    acd_fsm_t          st;
    logic              scan_mode;
    acd_dma_ctl_t      dctl;
    acd_conv_ctl_t     cctl;
    logic              ref_int_en;
    logic [RES_W-1:0]  res;
    logic [CHAN_W-1:0] idx;
    logic [IRQ_W-1:0]  stat;
    logic [IRQ_W-1:0]  mask;
    logic              irq;
    logic [DATA_W-1:0] prdata;
    logic              pready;
    logic              pslverr;
    logic              conv_start;
    logic [CHAN_W-1:0] conv_chan;
    logic              dma_req;
    logic [CHAN_W-1:0] dma_chan;
    logic [RES_W-1:0]  dma_data;
    logic [CNT_W-1:0]  age;
  } acd_state_t;
endpackage : acd_pkg

// ### hw/acd_timer.sv
`timescale 1ns/10ps
module acd_timer (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      load,
  input  wire logic [acd_pkg::CNT_W-1:0] load_val,
  output logic                           done
);
  typedef struct packed {
    logic [acd_pkg::CNT_W-1:0] cnt;
  } acd_tmr_state_t;

  acd_tmr_state_t tmr_reg;
  acd_tmr_state_t tmr_next;

  always_comb begin
    tmr_next = tmr_reg;
    if (load) begin
      tmr_next.cnt = load_val;
    end else if (tmr_reg.cnt != '0) begin
      tmr_next.cnt = tmr_reg.cnt - acd_pkg::CNT_ONE;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmr_reg <= '0;
    end else begin
      tmr_reg <= tmr_next;
    end
  end

  // High in the last cycle of a load_val long interval
  assign done = (tmr_reg.cnt == acd_pkg::CNT_ONE);
endmodule : acd_timer

// ### hw/acd_top.sv
// What this block does
// RULE_01 - Scan disabled: engine idle, last-input zero
// RULE_02 - Scan interrupt only when enabled, after last
// RULE_03 - Software writes zero to reserved scan bits
// RULE_04 - Scan starts input zero, ascends one by one
// RULE_05 - Scan converts, then DMA-transfers, repeatedly
// RULE_06 - Last-input n selects inputs zero to n
// RULE_07 - Start write begins or restarts conversion
// RULE_08 - Start bit reads one while converting
// RULE_09 - Reference bit zero enables internal reference
// RULE_10 - Single-shot result after 5129 cycles
// RULE_11 - Continuous result refresh every 256 cycles
// RULE_12 - Channel field picks inputs zero to eleven
// RULE_13 - Software avoids unbonded analog inputs
// RULE_14 - Ten-bit result read-only, high/low split
// RULE_15 - Results invalid during conversion, undefined reset
// RULE_16 - Low six result bits reserved
// RULE_17 - After last input, scan wraps to zero
`timescale 1ns/10ps
module acd_top #(
  parameter logic [acd_pkg::CNT_W-1:0] SINGLE_CYCLES = acd_pkg::SINGLE_CYCLES_DFLT
) (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [acd_pkg::ADDR_W-1:0] paddr,
  input  wire logic [acd_pkg::DATA_W-1:0] pwdata,
  input  wire logic [3:0]                 pstrb,
  output logic      [acd_pkg::DATA_W-1:0] prdata,
  output logic                            pready,
  output logic                            pslverr,
  output logic                            conv_start,
  output logic      [acd_pkg::CHAN_W-1:0] conv_chan,
  output logic                            ref_int_en,
  input  wire logic [acd_pkg::RES_W-1:0]  adc_sample,
  output logic                            dma_req,
  output logic      [acd_pkg::CHAN_W-1:0] dma_chan,
  output logic      [acd_pkg::RES_W-1:0]  dma_data,
  input  wire logic                       dma_ack,
  output logic                            irq
);
  acd_pkg::acd_state_t      r_reg;
  acd_pkg::acd_state_t      r_next;
  logic                     setup;
  logic                     wr_acc;
  logic                     hit;
  logic [11:0]              idx_a;
  logic                     start_wr;
  logic                     t_load;
  logic [acd_pkg::CNT_W-1:0] t_val;
  logic                     t_done;
  logic [acd_pkg::CHAN_W-1:0] last_c;
  logic [acd_pkg::IRQ_W-1:0] set_ev;
  logic [acd_pkg::CNT_W-1:0] conv_len;
  logic [acd_pkg::REG_W-1:0] rd_byte;

  acd_timer u_timer (
    .pclk     (pclk),
    .presetn  (presetn),
    .load     (t_load),
    .load_val (t_val),
    .done     (t_done)
  );

  assign idx_a  = paddr[acd_pkg::ADDR_W-1:2];
  assign setup  = psel && !penable;
  assign wr_acc = psel && penable && pwrite && r_reg.pready;

  always_comb begin
    r_next = r_reg;
    hit = (paddr[1:0] == acd_pkg::BYTE_OFS) &&
          (idx_a == acd_pkg::IDX_CONV_CTL || idx_a == acd_pkg::IDX_RES_HI ||
           idx_a == acd_pkg::IDX_RES_LO || idx_a == acd_pkg::IDX_IRQ_STAT ||
           idx_a == acd_pkg::IDX_IRQ_MASK || idx_a == acd_pkg::IDX_DMA_CTL);
    start_wr = 1'b0;
    t_load = 1'b0;
    t_val = acd_pkg::CONTINUOUS_SELECT_CYCLES;
    set_ev = '0;
    rd_byte = '0;
    r_next.conv_start = 1'b0;
    r_next.pready = 1'b0;
    r_next.pslverr = 1'b0;
    r_next.age = r_reg.age + acd_pkg::CNT_ONE;
    // Reserved last-input codes act as the top input
    last_c = (r_reg.dctl.last > acd_pkg::LAST_MAX) ? acd_pkg::LAST_MAX
                                                   : r_reg.dctl.last; // RULE_06
    conv_len = r_reg.cctl.continuous_select ? acd_pkg::CONTINUOUS_SELECT_CYCLES : SINGLE_CYCLES;

    // Read data is captured in the setup cycle, answered in the access cycle
    if (setup) begin
      unique case (idx_a)
        acd_pkg::IDX_CONV_CTL: rd_byte = r_reg.cctl; // RULE_08
        acd_pkg::IDX_RES_HI:   rd_byte = r_reg.res[acd_pkg::RES_W-1:2]; // RULE_14
        acd_pkg::IDX_RES_LO:   rd_byte = {r_reg.res[1:0], 6'h00}; // RULE_16
        acd_pkg::IDX_IRQ_STAT: rd_byte = {6'h00, r_reg.stat};
        acd_pkg::IDX_IRQ_MASK: rd_byte = {6'h00, r_reg.mask};
        acd_pkg::IDX_DMA_CTL:  rd_byte = r_reg.dctl;
        default:               rd_byte = '0;
      endcase
      r_next.pready = 1'b1;
      r_next.pslverr = !hit;
      r_next.prdata = {24'h000000, rd_byte};
    end

    if (wr_acc && hit && pstrb[0]) begin
      unique case (idx_a)
        acd_pkg::IDX_DMA_CTL: begin
          r_next.dctl = acd_pkg::acd_dma_ctl_t'(pwdata[acd_pkg::REG_W-1:0]);
          if (!r_next.dctl.en) begin
            r_next.dctl.last = '0; // RULE_01
          end
        end
        acd_pkg::IDX_CONV_CTL: begin
          r_next.cctl = acd_pkg::acd_conv_ctl_t'(pwdata[acd_pkg::REG_W-1:0]);
          r_next.cctl.start = r_reg.cctl.start;
          r_next.ref_int_en = !r_next.cctl.vref_ext; // RULE_09
          start_wr = pwdata[acd_pkg::REG_W-1];
        end
        acd_pkg::IDX_IRQ_STAT: r_next.stat = r_reg.stat & ~pwdata[acd_pkg::IRQ_W-1:0];
        acd_pkg::IDX_IRQ_MASK: r_next.mask = pwdata[acd_pkg::IRQ_W-1:0];
        default: ;
      endcase
    end

    unique case (r_reg.st)
      acd_pkg::ACD_IDLE: begin
        if (r_reg.dctl.en) begin
          r_next.scan_mode = 1'b1;
          r_next.idx = '0; // RULE_04
          r_next.conv_chan = '0;
          r_next.conv_start = 1'b1;
          r_next.age = '0;
          t_load = 1'b1;
          t_val = acd_pkg::CONTINUOUS_SELECT_CYCLES;
          r_next.st = acd_pkg::ACD_CONV;
        end else if (start_wr) begin
          r_next.scan_mode = 1'b0;
          r_next.cctl.start = 1'b1; // RULE_08
          r_next.conv_chan = r_next.cctl.chan; // RULE_12
          r_next.conv_start = 1'b1; // RULE_07
          r_next.age = '0;
          t_load = 1'b1;
          t_val = r_next.cctl.continuous_select ? acd_pkg::CONTINUOUS_SELECT_CYCLES : SINGLE_CYCLES;
          r_next.st = acd_pkg::ACD_CONV;
        end
      end
      acd_pkg::ACD_CONV: begin
        if (r_reg.scan_mode) begin
          if (!r_next.dctl.en) begin
            r_next.st = acd_pkg::ACD_IDLE; // RULE_01
          end else if (t_done) begin
            r_next.res = adc_sample; // RULE_05
            r_next.dma_req = 1'b1;
            r_next.dma_chan = r_reg.idx;
            r_next.dma_data = adc_sample;
            r_next.st = acd_pkg::ACD_XFER;
          end
        end else if (start_wr) begin
          // A new start throws away the running conversion
          r_next.conv_chan = r_next.cctl.chan; // RULE_12
          r_next.conv_start = 1'b1; // RULE_07
          r_next.age = '0;
          t_load = 1'b1;
          t_val = r_next.cctl.continuous_select ? acd_pkg::CONTINUOUS_SELECT_CYCLES : SINGLE_CYCLES;
        end else if (t_done) begin
          r_next.res = adc_sample; // RULE_15
          set_ev[acd_pkg::IRQ_CONV] = 1'b1;
          if (r_reg.cctl.continuous_select) begin
            r_next.conv_chan = r_reg.cctl.chan; // RULE_11
            r_next.conv_start = 1'b1;
            r_next.age = '0;
            t_load = 1'b1;
            t_val = conv_len;
          end else begin
            r_next.cctl.start = 1'b0; // RULE_08
            r_next.st = acd_pkg::ACD_IDLE; // RULE_10
          end
        end
      end
      acd_pkg::ACD_XFER: begin
        if (!r_next.dctl.en) begin
          r_next.dma_req = 1'b0;
          r_next.st = acd_pkg::ACD_IDLE; // RULE_01
        end else if (dma_ack) begin
          r_next.dma_req = 1'b0;
          if (r_reg.idx >= last_c) begin
            set_ev[acd_pkg::IRQ_SCAN] = r_reg.dctl.irq_en; // RULE_02
            r_next.idx = '0; // RULE_17
          end else begin
            r_next.idx = r_reg.idx + acd_pkg::CHAN_ONE; // RULE_04
          end
          r_next.conv_chan = r_next.idx;
          r_next.conv_start = 1'b1; // RULE_05
          r_next.age = '0;
          t_load = 1'b1;
          t_val = acd_pkg::CONTINUOUS_SELECT_CYCLES;
          r_next.st = acd_pkg::ACD_CONV;
        end
      end
      default: r_next.st = acd_pkg::ACD_IDLE;
    endcase

    // A new event wins over a clear in the same cycle
    r_next.stat = r_next.stat | set_ev;
    r_next.irq = |(r_next.stat & r_next.mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg <= '0;
      r_reg.st <= acd_pkg::ACD_IDLE;
      r_reg.dctl <= acd_pkg::DMA_CTL_RST;
      r_reg.cctl <= acd_pkg::CONV_CTL_RST;
      r_reg.ref_int_en <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  assign prdata     = r_reg.prdata;
  assign pready     = r_reg.pready;
  assign pslverr    = r_reg.pslverr;
  assign conv_start = r_reg.conv_start;
  assign conv_chan  = r_reg.conv_chan;
  assign ref_int_en = r_reg.ref_int_en;
  assign dma_req    = r_reg.dma_req;
  assign dma_chan   = r_reg.dma_chan;
  assign dma_data   = r_reg.dma_data;
  assign irq        = r_reg.irq;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic [acd_pkg::CNT_W-1:0] single_m1;
  logic [acd_pkg::CNT_W-1:0] continuous_select_m1;
  assign single_m1 = SINGLE_CYCLES - acd_pkg::CNT_ONE;
  assign continuous_select_m1   = acd_pkg::CONTINUOUS_SELECT_CYCLES - acd_pkg::CNT_ONE;

  a_last_forced_zero: assert property ( // RULE_01
    !r_reg.dctl.en |-> (r_reg.dctl.last == '0) && (r_reg.st != acd_pkg::ACD_XFER))
    else $error("Scan disabled but last field or engine active");

  a_scan_irq_gate: assert property ( // RULE_02
    $rose(r_reg.stat[acd_pkg::IRQ_SCAN]) |->
      $past(r_reg.dctl.irq_en) && $past(r_reg.st) == acd_pkg::ACD_XFER)
    else $error("Scan interrupt raised without enable or transfer");

  a_scan_ascends: assert property ( // RULE_04
    (r_reg.st == acd_pkg::ACD_XFER && r_next.dctl.en && dma_ack && r_reg.idx < last_c)
      |=> r_reg.idx == $past(r_reg.idx) + acd_pkg::CHAN_ONE)
    else $error("Scan did not advance by one input");

  a_scan_wraps: assert property ( // RULE_17
    (r_reg.st == acd_pkg::ACD_XFER && r_next.dctl.en && dma_ack && r_reg.idx >= last_c)
      |=> r_reg.idx == '0 && conv_start && conv_chan == '0)
    else $error("Scan did not wrap to input zero");

  a_start_busy: assert property ( // RULE_08
    (r_reg.st == acd_pkg::ACD_CONV && !r_reg.scan_mode) |-> r_reg.cctl.start)
    else $error("Start bit low during conversion");

  a_single_time: assert property ( // RULE_10
    (r_reg.st == acd_pkg::ACD_CONV && !r_reg.scan_mode && !r_reg.cctl.continuous_select &&
     t_done && !start_wr && r_reg.age != continuous_select_m1) |-> r_reg.age == single_m1 ##1 !r_reg.cctl.start)
    else $error("Single conversion length wrong");

  a_continuous_select_time: assert property ( // RULE_11
    (r_reg.st == acd_pkg::ACD_CONV && r_reg.cctl.continuous_select && t_done && !start_wr)
      |-> r_reg.age == continuous_select_m1)
    else $error("Continuous refresh period wrong");

  a_restart: assert property ( // RULE_07
    (r_reg.st == acd_pkg::ACD_CONV && !r_reg.scan_mode && start_wr)
      |=> conv_start && r_reg.age == '0 ##1 !t_done)
    else $error("Start write did not restart conversion");

  a_low_reserved: assert property ( // RULE_16
    (setup && idx_a == acd_pkg::IDX_RES_LO) |=> prdata[5:0] == 6'h00)
    else $error("Low result reserved bits not zero");

  a_xfer_data: assert property ( // RULE_05
    $rose(dma_req) |-> dma_data == r_reg.res && dma_chan == r_reg.idx)
    else $error("DMA data does not match result");

  c_single_done: cover property (
    r_reg.st == acd_pkg::ACD_CONV && !r_reg.scan_mode && t_done ##1
    r_reg.st == acd_pkg::ACD_IDLE);
  c_scan_wrap: cover property (
    r_reg.st == acd_pkg::ACD_XFER && dma_ack && r_reg.idx == last_c &&
    r_reg.idx != '0);
  c_irq_seen: cover property ($rose(irq));
endmodule : acd_top

// ### verif/acd_far_model.sv
`timescale 1ns/10ps
module acd_far_model (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic [acd_pkg::CHAN_W-1:0] conv_chan,
  input  wire logic                       dma_req,
  output logic      [acd_pkg::RES_W-1:0]  adc_sample,
  output logic                            dma_ack
);
  logic [2:0] wait_reg;
  logic       slow_reg;

  // Sample carries its channel so every result names its input
  assign adc_sample = {conv_chan, 2'h2, ~conv_chan};

  // Memory side alternates prompt and stalled acceptance of beats
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_reg <= 3'h0;
      slow_reg <= 1'b0;
      dma_ack  <= 1'b0;
    end else begin
      dma_ack <= 1'b0;
      if (dma_req && !dma_ack) begin
        if (wait_reg == (slow_reg ? 3'h5 : 3'h0)) begin
          dma_ack  <= 1'b1;
          wait_reg <= 3'h0;
          slow_reg <= ~slow_reg;
        end else begin
          wait_reg <= wait_reg + 3'h1;
        end
      end
    end
  end
endmodule : acd_far_model

// ### verif/tb.sv
`timescale 1ns/10ps
module tb;
  logic        pclk, presetn, psel, penable, pwrite;
  logic [13:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb, conv_chan, dma_chan;
  logic        pready, pslverr, conv_start, ref_int_en, dma_req, dma_ack, irq, err;
  logic [9:0]  adc_sample, dma_data;
  logic [3:0]  beats[$];
  int          fail_count, checks, n;

  acd_top #(.SINGLE_CYCLES(13'h0028)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .conv_start(conv_start),
    .conv_chan(conv_chan), .ref_int_en(ref_int_en), .adc_sample(adc_sample),
    .dma_req(dma_req), .dma_chan(dma_chan), .dma_data(dma_data), .dma_ack(dma_ack),
    .irq(irq));
  acd_far_model far (.pclk(pclk), .presetn(presetn), .conv_chan(conv_chan),
    .dma_req(dma_req), .adc_sample(adc_sample), .dma_ack(dma_ack));

  function automatic logic [9:0] smp(input logic [3:0] c);
    return {c, 2'h2, ~c};
  endfunction : smp

  task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [11:0] idx, input logic [7:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx, 2'h0};
    pwdata  <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic edges_until_irq();
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (irq !== 1'b1 && n < 200);
  endtask : edges_until_irq

  task automatic wait_start();
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (conv_start !== 1'b1 && n < 600);
  endtask : wait_start

  task automatic t_reset();
    apb(1'b0, acd_pkg::IDX_DMA_CTL, 8'h00);
    chk("scan_ctl_rst", rd, 32'h0);
    apb(1'b0, acd_pkg::IDX_CONV_CTL, 8'h00);
    chk("conv_ctl_rst", rd, 32'h0);
    chk("ref_int_en_rst", ref_int_en, 1'b1);
    apb(1'b0, 12'h100, 8'h00);
    chk("unmapped_err", err, 1'b1);
  endtask : t_reset

  task automatic t_vref();
    apb(1'b1, acd_pkg::IDX_CONV_CTL, 8'h20);
    @(posedge pclk);
    chk("ref_ext", ref_int_en, 1'b0);
    apb(1'b1, acd_pkg::IDX_CONV_CTL, 8'h00);
    @(posedge pclk);
    chk("ref_int", ref_int_en, 1'b1);
  endtask : t_vref

  task automatic t_single();
    apb(1'b1, acd_pkg::IDX_IRQ_MASK, 8'h01);
    apb(1'b1, acd_pkg::IDX_CONV_CTL, 8'h8b);
    edges_until_irq();
    chk("single_time", (n >= 40 && n <= 43), 1'b1);
    chk("conv_chan", conv_chan, 4'hb);
    apb(1'b0, acd_pkg::IDX_CONV_CTL, 8'h00);
    chk("start_clear", rd[7], 1'b0);
    apb(1'b0, acd_pkg::IDX_RES_HI, 8'h00);
    chk("res_hi", rd, 32'(smp(4'hb) >> 2));
    apb(1'b1, acd_pkg::IDX_RES_LO, 8'hff);
    apb(1'b0, acd_pkg::IDX_RES_LO, 8'h00);
    chk("res_lo", rd[7:6], smp(4'hb) & 10'h003);
    apb(1'b1, acd_pkg::IDX_IRQ_STAT, 8'h01);
    @(posedge pclk);
    chk("irq_w1c", irq, 1'b0);
  endtask : t_single

  task automatic t_restart();
    apb(1'b1, acd_pkg::IDX_CONV_CTL, 8'h85);
    repeat (10) @(posedge pclk);
    apb(1'b0, acd_pkg::IDX_CONV_CTL, 8'h00);
    chk("busy_bit", rd, 32'h85);
    apb(1'b1, acd_pkg::IDX_CONV_CTL, 8'h85);
    edges_until_irq();
    chk("restart_time", (n >= 40 && n <= 43), 1'b1);
    apb(1'b1, acd_pkg::IDX_IRQ_MASK, 8'h00);
    @(posedge pclk);
    chk("irq_masked", irq, 1'b0);
    apb(1'b1, acd_pkg::IDX_IRQ_STAT, 8'h01);
  endtask : t_restart

  task automatic t_continuous_select();
    apb(1'b1, acd_pkg::IDX_CONV_CTL, 8'h91);
    wait_start();
    wait_start();
    chk("continuous_select_period", n, 256);
    apb(1'b1, acd_pkg::IDX_CONV_CTL, 8'h01);
    repeat (300) @(posedge pclk);
    apb(1'b0, acd_pkg::IDX_CONV_CTL, 8'h00);
    chk("continuous_select_stop", rd[7], 1'b0);
  endtask : t_continuous_select

  task automatic t_scan(input logic [7:0] ctl, input int nb, input logic expirq);
    apb(1'b1, acd_pkg::IDX_IRQ_STAT, 8'h03);
    apb(1'b1, acd_pkg::IDX_IRQ_MASK, 8'h02);
    beats.delete();
    apb(1'b1, acd_pkg::IDX_DMA_CTL, ctl);
    n = 0;
    while (beats.size() < nb && n < 4000) begin
      @(posedge pclk);
      n++;
    end
    for (int i = 0; i < nb; i++) begin
      chk("scan_chan", beats[i], (i % 3));
    end
    chk("scan_irq", irq, expirq);
    apb(1'b1, acd_pkg::IDX_DMA_CTL, ctl & 8'h42);
    apb(1'b0, acd_pkg::IDX_DMA_CTL, 8'h00);
    chk("scan_off_ctl", rd, {24'h0, ctl & 8'h40});
    repeat (300) @(posedge pclk);
    chk("scan_idle", dma_req, 1'b0);
  endtask : t_scan

  task automatic results();
    if (fail_count == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : results

  // Each accepted beat must carry the result of its own input
  always @(posedge pclk) begin
    if (dma_req === 1'b1 && dma_ack === 1'b1) begin
      beats.push_back(dma_chan);
      chk("dma_data", dma_data, smp(dma_chan));
    end
  end

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  initial begin
    #(25 * 20000);
    fail_count++;
    results();
  end

  initial begin
    {presetn, psel, penable, pwrite} = 4'h0;
    paddr = 14'h0;
    pwdata = 32'h0;
    pstrb = 4'hf;
    fail_count = 0;
    checks = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_vref();
    t_single();
    t_restart();
    t_continuous_select();
    t_scan(8'hc2, 4, 1'b1);
    t_scan(8'h82, 3, 1'b0);
    results();
  end
endmodule : tb
